/* data_transfer_instruction_exec_test.sv */
`timescale 1ns/1ns
`include "dte_exec_map.vh"
// ----------------------------------------
// Random transfer sequences
// ----------------------------------------
module data_transfer_instruction_exec_test;
    reg clk_i, rst_i, instr_valid_i, debug_en_i;
    reg [31:0] instr_i, r32;
    reg [7:0] io_rdata_i, v;
    reg [4:0] reg_sel_i;
    reg [15:0] a;
    reg [5:0] q;
    reg [1:0] p, pz;
    wire ready_o, done_o, dmem_re_o, dmem_we_o, pmem_re_o, io_we_o, sleep_o, wdog_o, brk_o;
    wire [15:0] dmem_addr_o, pmem_addr_o, sp_o;
    wire [7:0] dmem_wdata_o, dmem_rdata, pmem_rdata, io_wdata_o, reg_data_o;
    wire [5:0] io_addr_o;
    integer miscompares = 0, check_count = 0, cycles = 0, seed = 36051, it;
    dte_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .debug_en_i(debug_en_i), .dmem_rdata_i(dmem_rdata),
        .pmem_rdata_i(pmem_rdata), .io_rdata_i(io_rdata_i), .reg_sel_i(reg_sel_i),
        .ready_o(ready_o), .done_o(done_o), .dmem_addr_o(dmem_addr_o),
        .dmem_wdata_o(dmem_wdata_o), .dmem_re_o(dmem_re_o), .dmem_we_o(dmem_we_o),
        .pmem_addr_o(pmem_addr_o), .pmem_re_o(pmem_re_o), .io_addr_o(io_addr_o),
        .io_wdata_o(io_wdata_o), .io_we_o(io_we_o), .sleep_o(sleep_o),
        .wdog_restart_o(wdog_o), .break_o(brk_o), .reg_data_o(reg_data_o), .sp_o(sp_o));
    dte_mem_model mem_u (.clk_i(clk_i), .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o),
        .dmem_re_i(dmem_re_o), .dmem_we_i(dmem_we_o), .pmem_addr_i(pmem_addr_o),
        .pmem_re_i(pmem_re_o), .dmem_rdata_o(dmem_rdata), .pmem_rdata_o(pmem_rdata));
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task conclude;
    begin
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    end
    endtask
    function [7:0] fp(input [15:0] x);
        fp = x[7:0] ^ x[15:8] ^ 8'h96;
    endfunction
    // Counts cycles from accept to done; also checks the count
    task run(input [5:0] op, input [1:0] ps, input [4:0] r, input [15:0] x, input integer n);
        integer k;
    begin
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= {op, ps, 3'h0, r, x};
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        k = 1;
        @(negedge clk_i);
        while (done_o !== 1'b1 && k < 8)
        begin
            k = k + 1;
            @(negedge clk_i);
        end
        check(k, n);
    end
    endtask
    task rdreg(input [4:0] r, input [7:0] exp);
    begin
        @(posedge clk_i);
        reg_sel_i <= r;
        @(posedge clk_i);
        @(negedge clk_i);
        check(reg_data_o, exp);
    end
    endtask
    task setp(input [1:0] ps, input [15:0] x);
    begin
        run(`DTE_OP_IMM, 2'h0, 5'h1A + {2'h0, ps, 1'b0}, {8'h00, x[7:0]}, 1);
        run(`DTE_OP_IMM, 2'h0, 5'h1B + {2'h0, ps, 1'b0}, {8'h00, x[15:8]}, 1);
    end
    endtask
    task chkp(input [1:0] ps, input [15:0] x);
    begin
        rdreg(5'h1A + {2'h0, ps, 1'b0}, x[7:0]);
        rdreg(5'h1B + {2'h0, ps, 1'b0}, x[15:8]);
    end
    endtask
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    initial
    begin
        rst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = 32'h0;
        debug_en_i = 1'b0;
        io_rdata_i = 8'h00;
        reg_sel_i = 5'h00;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(sp_o, 16'h00FF);
        for (it = 0; it < 16; it = it + 1)
        begin
            r32 = $random(seed);
            a = r32[15:0];
            v = r32[23:16];
            q = r32[29:24] | 6'h02;
            p = it % 3;
            pz = 2'h1 + it % 2;
            setp(p, a);
            run(`DTE_OP_IMM, 2'h0, 5'h05, {8'h00, v}, 1);
            run(`DTE_OP_IMM, 2'h0, 5'h07, {8'h00, ~v}, 1);
            run(`DTE_OP_STORE_INC, p, 5'h05, 16'h0, 2);
            run(`DTE_OP_LOAD_DEC, p, 5'h06, 16'h0, 2);
            run(`DTE_OP_STORE_DEC, p, 5'h07, 16'h0, 2);
            run(`DTE_OP_LOAD_INC, p, 5'h08, 16'h0, 2);
            run(`DTE_OP_LOAD_IND, p, 5'h09, 16'h0, 2);
            run(`DTE_OP_STORE_IND, p, 5'h07, 16'h0, 2);
            run(`DTE_OP_LOAD_IND, p, 5'h0A, 16'h0, 2);
            chkp(p, a);
            rdreg(5'h06, v);
            rdreg(5'h08, ~v);
            rdreg(5'h09, v);
            rdreg(5'h0A, ~v);
            setp(pz, a);
            run(`DTE_OP_STORE_OFS, pz, 5'h05, {10'h0, q}, 2);
            run(`DTE_OP_LOAD_DIR, 2'h0, 5'h0B, a + q, 2);
            run(`DTE_OP_STORE_DIR, 2'h0, 5'h07, a + q, 2);
            run(`DTE_OP_LOAD_OFS, pz, 5'h0C, {10'h0, q}, 2);
            chkp(pz, a);
            rdreg(5'h0B, v);
            rdreg(5'h0C, ~v);
            setp(`DTE_PTR_Z, a);
            run(`DTE_OP_PROG_RD_INC, 2'h0, 5'h0D, 16'h0, 3);
            run(`DTE_OP_PROG_RD, 2'h0, 5'h0E, 16'h0, 3);
            rdreg(5'h0D, fp(a));
            rdreg(5'h0E, fp(a + 16'h1));
            chkp(`DTE_PTR_Z, a + 16'h1);
            run(`DTE_OP_PUSH, 2'h0, 5'h05, 16'h0, 2);
            run(`DTE_OP_PUSH, 2'h0, 5'h07, 16'h0, 2);
            check(sp_o, 16'h00FD);
            run(`DTE_OP_POP, 2'h0, 5'h0F, 16'h0, 2);
            run(`DTE_OP_POP, 2'h0, 5'h10, 16'h0, 2);
            check(sp_o, 16'h00FF);
            rdreg(5'h0F, ~v);
            rdreg(5'h10, v);
            run(`DTE_OP_COPY, 2'h0, 5'h11, 16'h5, 1);
            run(`DTE_OP_PAIR_COPY, 2'h0, 5'h12, 16'h6, 1);
            @(posedge clk_i);
            io_rdata_i <= v ^ 8'h5A;
            run(`DTE_OP_PORT_IN, 2'h0, 5'h14, {10'h0, q}, 1);
            rdreg(5'h11, v);
            rdreg(5'h13, ~v);
            rdreg(5'h14, v ^ 8'h5A);
            run(`DTE_OP_PORT_OUT, 2'h0, 5'h05, {10'h0, q}, 1);
            check({io_we_o, io_addr_o, io_wdata_o}, {1'b1, q, v});
            run(`DTE_OP_SLEEP, 2'h0, 5'h00, 16'h0, 1);
            check(sleep_o, 1'b1);
            run(`DTE_OP_WDOG, 2'h0, 5'h00, 16'h0, 1);
            check(wdog_o, 1'b1);
            @(posedge clk_i);
            debug_en_i <= it[0];
            run(`DTE_OP_BREAK, 2'h0, 5'h00, 16'h0, 1);
            check(brk_o, it[0]);
            run(6'h3F, 2'h0, 5'h00, 16'h0, 1);
        end
        conclude;
    end
endmodule // data_transfer_instruction_exec_test

/* dte_exec.v */
`timescale 1ns/1ns
`include "dte_exec_map.vh"

module dte_exec #(
    parameter [15:0] SP_RESET = `DTE_SP_RESET
) (
    input wire clk_i,
    input wire rst_i,
    input wire instr_valid_i,
    input wire [31:0] instr_i,
    input wire debug_en_i,
    input wire [7:0] dmem_rdata_i,
    input wire [7:0] pmem_rdata_i,
    input wire [7:0] io_rdata_i,
    input wire [4:0] reg_sel_i,
    output wire ready_o,
    output wire done_o,
    output wire [15:0] dmem_addr_o,
    output wire [7:0] dmem_wdata_o,
    output wire dmem_re_o,
    output wire dmem_we_o,
    output wire [15:0] pmem_addr_o,
    output wire pmem_re_o,
    output wire [5:0] io_addr_o,
    output wire [7:0] io_wdata_o,
    output wire io_we_o,
    output wire sleep_o,
    output wire wdog_restart_o,
    output wire break_o,
    output wire [7:0] reg_data_o,
    output wire [15:0] sp_o
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_DATA = 4'b0010;
localparam [3:0] S_PROG1 = 4'b0100;
localparam [3:0] S_PROG2 = 4'b1000;

// ----------------------------------------
// Storage
// ----------------------------------------
reg [7:0] rf [0:31];
reg [3:0] state_q;
reg [4:0] dst_q;
reg [15:0] sp_q, dmem_addr_q, pmem_addr_q;
reg [7:0] dmem_wdata_q, io_wdata_q, reg_data_q;
reg [5:0] io_addr_q;
reg ready_q, done_q, dmem_re_q, dmem_we_q, pmem_re_q, io_we_q, sleep_q, wdog_q, brk_q;
integer i;

// ----------------------------------------
// Pointer decode
// ----------------------------------------
function [4:0] ptr_lo;
    input [1:0] sel;
    begin
        case (sel)
            `DTE_PTR_Y: ptr_lo = `DTE_Y_LO;
            `DTE_PTR_Z: ptr_lo = `DTE_Z_LO;
            default: ptr_lo = `DTE_X_LO;
        endcase
    end
endfunction

wire [5:0] op = instr_i[`DTE_OP_MSB:`DTE_OP_LSB];
wire [1:0] sel = instr_i[`DTE_PTR_MSB:`DTE_PTR_LSB];
wire [4:0] rd = instr_i[`DTE_REG_MSB:`DTE_REG_LSB];
wire [15:0] aux = instr_i[`DTE_AUX_MSB:`DTE_AUX_LSB];
wire [4:0] rr = aux[4:0];
wire accept = instr_valid_i & ready_q;

// Offset forms reach only the second and third pairs
wire [1:0] ofs_sel = (sel == `DTE_PTR_Z) ? `DTE_PTR_Z : `DTE_PTR_Y;
wire [4:0] plo = ptr_lo(sel);
wire [4:0] olo = ptr_lo(ofs_sel);
wire [15:0] pval = {rf[plo | 5'h01], rf[plo]};
wire [15:0] oval = {rf[olo | 5'h01], rf[olo]};
wire [15:0] zval = {rf[`DTE_Z_LO | 5'h01], rf[`DTE_Z_LO]};

reg [15:0] eff_addr, ptr_new;
reg ptr_wr, mem_rd, mem_wr;

// ----------------------------------------
// Address generation
// ----------------------------------------
always @*
begin
    eff_addr = pval;
    ptr_new = pval;
    ptr_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    case (op)
        `DTE_OP_LOAD_IND:
            mem_rd = 1'b1;
        `DTE_OP_LOAD_INC:
        begin
            mem_rd = 1'b1;
            ptr_wr = 1'b1;
            ptr_new = pval + 16'h0001;
        end
        `DTE_OP_LOAD_DEC:
        begin
            mem_rd = 1'b1;
            ptr_wr = 1'b1;
            ptr_new = pval - 16'h0001;
            eff_addr = pval - 16'h0001;
        end
        `DTE_OP_LOAD_OFS:
        begin
            mem_rd = 1'b1;
            eff_addr = oval + {10'h000, aux[5:0]};
        end
        `DTE_OP_LOAD_DIR:
        begin
            mem_rd = 1'b1;
            eff_addr = aux;
        end
        `DTE_OP_STORE_IND:
            mem_wr = 1'b1;
        `DTE_OP_STORE_INC:
        begin
            mem_wr = 1'b1;
            ptr_wr = 1'b1;
            ptr_new = pval + 16'h0001;
        end
        `DTE_OP_STORE_DEC:
        begin
            mem_wr = 1'b1;
            ptr_wr = 1'b1;
            ptr_new = pval - 16'h0001;
            eff_addr = pval - 16'h0001;
        end
        `DTE_OP_STORE_OFS:
        begin
            mem_wr = 1'b1;
            eff_addr = oval + {10'h000, aux[5:0]};
        end
        `DTE_OP_STORE_DIR:
        begin
            mem_wr = 1'b1;
            eff_addr = aux;
        end
        `DTE_OP_PUSH:
        begin
            mem_wr = 1'b1;
            eff_addr = sp_q;
        end
        `DTE_OP_POP:
        begin
            mem_rd = 1'b1;
            eff_addr = sp_q + 16'h0001;
        end
        default:
            mem_rd = 1'b0;
    endcase
end

// ----------------------------------------
// Sequencer and register file
// ----------------------------------------
// No status register is written anywhere: all ops here keep the flags
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        for (i = 0; i < 32; i = i + 1)
            rf[i] <= 8'h00;
        state_q <= S_IDLE;
        ready_q <= 1'b1;
        done_q <= 1'b0;
        dst_q <= 5'h00;
        sp_q <= SP_RESET;
        dmem_addr_q <= 16'h0000;
        dmem_wdata_q <= 8'h00;
        dmem_re_q <= 1'b0;
        dmem_we_q <= 1'b0;
        pmem_addr_q <= 16'h0000;
        pmem_re_q <= 1'b0;
        io_addr_q <= 6'h00;
        io_wdata_q <= 8'h00;
        io_we_q <= 1'b0;
        sleep_q <= 1'b0;
        wdog_q <= 1'b0;
        brk_q <= 1'b0;
        reg_data_q <= 8'h00;
    end
    else
    begin
        done_q <= 1'b0;
        dmem_re_q <= 1'b0;
        dmem_we_q <= 1'b0;
        pmem_re_q <= 1'b0;
        io_we_q <= 1'b0;
        sleep_q <= 1'b0;
        wdog_q <= 1'b0;
        brk_q <= 1'b0;
        reg_data_q <= rf[reg_sel_i];
        case (state_q)
            S_IDLE:
            begin
                if (accept)
                begin
                    dst_q <= rd;
                    if (mem_rd | mem_wr)
                    begin
                        // Address is latched now, so the pointer can move at once
                        dmem_addr_q <= eff_addr;
                        dmem_wdata_q <= rf[rd];
                        dmem_re_q <= mem_rd;
                        dmem_we_q <= mem_wr;
                        ready_q <= 1'b0;
                        state_q <= S_DATA;
                        if (ptr_wr)
                        begin
                            rf[plo] <= ptr_new[7:0];
                            rf[plo | 5'h01] <= ptr_new[15:8];
                        end
                        if (op == `DTE_OP_PUSH)
                            sp_q <= sp_q - 16'h0001;
                        if (op == `DTE_OP_POP)
                            sp_q <= sp_q + 16'h0001;
                    end
                    else
                    begin
                        done_q <= 1'b1;
                        case (op)
                            `DTE_OP_COPY:
                                rf[rd] <= rf[rr];
                            `DTE_OP_PAIR_COPY:
                            begin
                                rf[{rd[4:1], 1'b0}] <= rf[{rr[4:1], 1'b0}];
                                rf[{rd[4:1], 1'b1}] <= rf[{rr[4:1], 1'b1}];
                            end
                            `DTE_OP_IMM:
                                rf[rd] <= aux[7:0];
                            `DTE_OP_PORT_IN:
                                rf[rd] <= io_rdata_i;
                            `DTE_OP_PORT_OUT:
                            begin
                                io_addr_q <= aux[5:0];
                                io_wdata_q <= rf[rd];
                                io_we_q <= 1'b1;
                            end
                            `DTE_OP_PROG_RD, `DTE_OP_PROG_RD_INC:
                            begin
                                pmem_addr_q <= zval;
                                pmem_re_q <= 1'b1;
                                ready_q <= 1'b0;
                                done_q <= 1'b0;
                                state_q <= S_PROG1;
                                if (op == `DTE_OP_PROG_RD_INC)
                                begin
                                    rf[`DTE_Z_LO] <= zval[7:0] + 8'h01;
                                    rf[`DTE_Z_LO | 5'h01] <= zval[15:8] + {7'h00, &zval[7:0]};
                                end
                            end
                            `DTE_OP_SLEEP:
                                sleep_q <= 1'b1;
                            `DTE_OP_WDOG:
                                wdog_q <= 1'b1;
                            `DTE_OP_BREAK:
                                brk_q <= debug_en_i;
                            default:
                                sleep_q <= 1'b0;
                        endcase
                    end
                end
            end
            S_DATA:
            begin
                // A load into a pointer register overrides the pointer update
                if (dmem_re_q)
                    rf[dst_q] <= dmem_rdata_i;
                done_q <= 1'b1;
                ready_q <= 1'b1;
                state_q <= S_IDLE;
            end
            S_PROG1:
            begin
                // Flash answers one cycle after its read strobe
                state_q <= S_PROG2;
            end
            S_PROG2:
            begin
                rf[dst_q] <= pmem_rdata_i;
                done_q <= 1'b1;
                ready_q <= 1'b1;
                state_q <= S_IDLE;
            end
            default:
            begin
                ready_q <= 1'b1;
                state_q <= S_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign ready_o = ready_q;
assign done_o = done_q;
assign dmem_addr_o = dmem_addr_q;
assign dmem_wdata_o = dmem_wdata_q;
assign dmem_re_o = dmem_re_q;
assign dmem_we_o = dmem_we_q;
assign pmem_addr_o = pmem_addr_q;
assign pmem_re_o = pmem_re_q;
assign io_addr_o = io_addr_q;
assign io_wdata_o = io_wdata_q;
assign io_we_o = io_we_q;
assign sleep_o = sleep_q;
assign wdog_restart_o = wdog_q;
assign break_o = brk_q;
assign reg_data_o = reg_data_q;
assign sp_o = sp_q;

endmodule // dte_exec

/* dte_exec_map.vh */
`ifndef DTE_EXEC_MAP_VH
`define DTE_EXEC_MAP_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define DTE_OP_MSB 31
`define DTE_OP_LSB 26
`define DTE_PTR_MSB 25
`define DTE_PTR_LSB 24
`define DTE_REG_MSB 20
`define DTE_REG_LSB 16
`define DTE_AUX_MSB 15
`define DTE_AUX_LSB 0

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define DTE_OP_IDLE 6'h00
`define DTE_OP_COPY 6'h01
`define DTE_OP_PAIR_COPY 6'h02
`define DTE_OP_IMM 6'h03
`define DTE_OP_PORT_IN 6'h04
`define DTE_OP_PORT_OUT 6'h05
`define DTE_OP_LOAD_IND 6'h08
`define DTE_OP_LOAD_INC 6'h09
`define DTE_OP_LOAD_DEC 6'h0A
`define DTE_OP_LOAD_OFS 6'h0B
`define DTE_OP_LOAD_DIR 6'h0C
`define DTE_OP_STORE_IND 6'h10
`define DTE_OP_STORE_INC 6'h11
`define DTE_OP_STORE_DEC 6'h12
`define DTE_OP_STORE_OFS 6'h13
`define DTE_OP_STORE_DIR 6'h14
`define DTE_OP_PROG_RD 6'h18
`define DTE_OP_PROG_RD_INC 6'h19
`define DTE_OP_PUSH 6'h1C
`define DTE_OP_POP 6'h1D
`define DTE_OP_SLEEP 6'h20
`define DTE_OP_WDOG 6'h21
`define DTE_OP_BREAK 6'h22

// ----------------------------------------
// Pointer pairs
// ----------------------------------------
`define DTE_PTR_X 2'h0
`define DTE_PTR_Y 2'h1
`define DTE_PTR_Z 2'h2
`define DTE_X_LO 5'h1A
`define DTE_Y_LO 5'h1C
`define DTE_Z_LO 5'h1E

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DTE_SP_RESET 16'h00FF

`endif

/* dte_exec_props.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Timing checks at the ports
// ----------------------------------------
module dte_exec_props (
    input wire clk_i,
    input wire rst_i,
    input wire instr_valid_i,
    input wire [31:0] instr_i,
    input wire debug_en_i,
    input wire ready_o,
    input wire done_o,
    input wire [15:0] dmem_addr_o,
    input wire dmem_re_o,
    input wire dmem_we_o,
    input wire pmem_re_o,
    input wire sleep_o,
    input wire wdog_restart_o,
    input wire break_o,
    input wire [15:0] sp_o
);
    wire take = instr_valid_i && ready_o;
    wire [5:0] op = instr_i[31:26];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_mem_timing:
    assert property (take && op inside {[6'h08:6'h0C], [6'h10:6'h14], 6'h1C, 6'h1D}
        |=> !ready_o && (dmem_re_o || dmem_we_o) ##1 done_o && ready_o)
    else $error("data op timing wrong");
    chk_mem_busy:
    assert property ((dmem_re_o || dmem_we_o) |-> !ready_o ##1 !(dmem_re_o || dmem_we_o))
    else $error("ready during memory strobe");
    chk_flash_wait:
    assert property (take && op inside {6'h18, 6'h19}
        |=> pmem_re_o && !ready_o ##1 !ready_o ##1 done_o && ready_o)
    else $error("flash read timing wrong");
    chk_one_cycle:
    assert property (take && op inside {[6'h00:6'h05], 6'h20, 6'h21, 6'h22} |=> done_o && ready_o)
    else $error("single cycle op late");
    chk_push_sp:
    assert property (take && op == 6'h1C
        |=> sp_o == $past(sp_o) - 16'h1 && dmem_addr_o == $past(sp_o) && dmem_we_o)
    else $error("push stack pointer wrong");
    chk_pop_sp:
    assert property (take && op == 6'h1D
        |=> sp_o == $past(sp_o) + 16'h1 && dmem_addr_o == $past(sp_o) + 16'h1 && dmem_re_o)
    else $error("pop stack pointer wrong");
    chk_direct_addr:
    assert property (take && op inside {6'h0C, 6'h14} |=> dmem_addr_o == $past(instr_i[15:0]))
    else $error("direct address wrong");
    chk_sleep_pulse:
    assert property (take && op == 6'h20 |=> sleep_o
        ##1 (!sleep_o || ($past(instr_valid_i) && $past(instr_i[31:26]) == 6'h20)))
    else $error("sleep pulse wrong");
    chk_wdog_pulse:
    assert property (take && op == 6'h21 |=> wdog_restart_o && done_o)
    else $error("watchdog pulse missing");
    chk_break_gate:
    assert property (take && op == 6'h22 |=> break_o == $past(debug_en_i) && done_o)
    else $error("break gating wrong");
endmodule // dte_exec_props

bind dte_exec dte_exec_props chk_u (.clk_i, .rst_i, .instr_valid_i, .instr_i, .debug_en_i,
    .ready_o, .done_o, .dmem_addr_o, .dmem_re_o, .dmem_we_o, .pmem_re_o, .sleep_o,
    .wdog_restart_o, .break_o, .sp_o);

/* dte_mem_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Data SRAM, stack and flash
// ----------------------------------------
module dte_mem_model (
    input wire clk_i,
    input wire [15:0] dmem_addr_i,
    input wire [7:0] dmem_wdata_i,
    input wire dmem_re_i,
    input wire dmem_we_i,
    input wire [15:0] pmem_addr_i,
    input wire pmem_re_i,
    output wire [7:0] dmem_rdata_o,
    output wire [7:0] pmem_rdata_o
);
    reg [7:0] mem_q [0:255];
    reg [7:0] dlast_q = 8'h00;
    reg [7:0] pdata_q = 8'h00;
    reg pvalid_q = 1'b0;
    // Inverted data outside a read so a mistimed sample cannot pass
    assign dmem_rdata_o = dmem_re_i ? mem_q[dmem_addr_i[7:0]] : ~dlast_q;
    assign pmem_rdata_o = pvalid_q ? pdata_q : ~pdata_q;
    always @(posedge clk_i)
    begin
        pvalid_q <= pmem_re_i;
        if (pmem_re_i)
            pdata_q <= pmem_addr_i[7:0] ^ pmem_addr_i[15:8] ^ 8'h96;
        if (dmem_re_i)
            dlast_q <= mem_q[dmem_addr_i[7:0]];
        if (dmem_we_i)
            mem_q[dmem_addr_i[7:0]] <= dmem_wdata_i;
    end
endmodule // dte_mem_model
